// ### hdl/nvac_top.sv
// Purpose: APB-reached controller for byte read and write of a data EEPROM
// Assumes: Single clock, synchronous active-low reset, EEPROM array held here
// Notes:   ID area reads return zero, program region reads are refused; neither region stores writes
//
// The register addresses and the APB interface to the registers were decided locally.
module nvac_top #(
  parameter int ADDR_W      = 10,
  parameter int PROG_CYCLES = nvac_pkg::PROG_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             nv_done_irq_o
);
  localparam int DEPTH = 1 << ADDR_W;

  // The address registers carry at most 16 bits of location
  if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr_w
    $error("ADDR_W must lie between 1 and 16");
  end

  // The programming counter is PROG_CNT_W bits wide
  if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << nvac_pkg::PROG_CNT_W)) begin : g_bad_prog
    $error("PROG_CYCLES does not fit the programming timer");
  end

  // Every control field must sit in the byte that software sees
  if (nvac_pkg::POS_REGION > 6 || nvac_pkg::BIT_WRITE_ERR > 7) begin : g_bad_fields
    $error("Control field positions do not fit one byte");
  end

  logic [7:0]   ee_mem [DEPTH];
  logic [7:0]   nv_data_reg;
  logic [7:0]   nv_addr_low_reg;
  logic [7:0]   nv_addr_high_reg;
  logic [1:0]   nv_region_select;
  logic         write_enable_bit;
  logic         write_error_flag;
  logic         write_start_reg;
  logic         read_start_reg;
  logic         nv_done_irq_flag;
  logic [7:0]   wr_data_reg;
  logic [15:0]  wr_addr_reg;
  logic         wr_region_ee_reg;

  logic         access;
  logic         wr_acc;
  logic         rd_acc;
  logic         ctrl_we;
  logic         key_we;
  logic         unlock_armed;
  logic         timer_expire;
  logic         data_we;
  logic         addr_low_we;
  logic         addr_high_we;
  logic         irq_we;
  logic         req_read;
  logic         req_write;
  logic         req_enable;
  logic         req_err_keep;
  logic [1:0]   wr_region;
  logic         wr_region_ee;
  logic         addr_bad;
  logic         start_write;
  logic         start_read;
  logic [15:0]  full_addr;
  logic [7:0]   nv_control_reg;
  logic [31:0]  rd_value;

  function automatic logic in_range(input logic [15:0] a);
    return (a >> ADDR_W) == 16'h0000;
  endfunction

  // Region field as carried by a control write
  function automatic logic [1:0] region_of(input logic [31:0] d);
    return d[nvac_pkg::POS_REGION +: 2];
  endfunction

  // Offsets past the last register, or not word aligned, are refused
  function automatic logic offset_bad(input logic [7:0] a);
    return (a > nvac_pkg::OFS_IRQ_FLAGS) || (a[1:0] != 2'h0);
  endfunction

  // Effects land in the first access cycle only, so the answer cycle repeats nothing
  assign access  = psel_i && penable_i && !pready_o;
  assign wr_acc  = access && pwrite_i;
  assign rd_acc  = access && !pwrite_i;
  assign ctrl_we = wr_acc && (paddr_i == nvac_pkg::OFS_CONTROL);
  assign key_we  = wr_acc && (paddr_i == nvac_pkg::OFS_UNLOCK);
  assign data_we      = wr_acc && (paddr_i == nvac_pkg::OFS_DATA);
  assign addr_low_we  = wr_acc && (paddr_i == nvac_pkg::OFS_ADDR_LOW);
  assign addr_high_we = wr_acc && (paddr_i == nvac_pkg::OFS_ADDR_HIGH);
  assign irq_we       = wr_acc && (paddr_i == nvac_pkg::OFS_IRQ_FLAGS);
  assign addr_bad     = offset_bad(paddr_i);

  // Control write fields, decoded once for every consumer
  assign req_read     = pwdata_i[nvac_pkg::BIT_READ_START];
  assign req_write    = pwdata_i[nvac_pkg::BIT_WRITE_START];
  assign req_enable   = pwdata_i[nvac_pkg::BIT_WRITE_EN];
  assign req_err_keep = pwdata_i[nvac_pkg::BIT_WRITE_ERR];
  assign wr_region    = region_of(pwdata_i);
  assign wr_region_ee = (wr_region == nvac_pkg::REGION_DATA_EE);

  assign full_addr = {nv_addr_high_reg, nv_addr_low_reg};

  // Write start needs enable and the unlock immediately before it
  assign start_write = ctrl_we && req_write && !write_start_reg
                       && write_enable_bit && unlock_armed
                       && req_enable;
  // Read start refused in program memory region, and while a write runs
  assign start_read = ctrl_we && req_read && !write_start_reg
                      && (wr_region != nvac_pkg::REGION_PROGRAM)
                      && !start_write;

  // Any control write consumes the unlock, so a stray one disarms it
  nvac_unlock u_unlock (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .key_we_i   (key_we),
    .key_i      (pwdata_i[7:0]),
    .other_we_i (wr_acc && !key_we && !ctrl_we),
    .consume_i  (ctrl_we),
    .armed_o    (unlock_armed)
  );

  // Busy is not needed: write-start already spans the whole erase/write
  nvac_prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .start_i  (start_write),
    .busy_o   (),
    .expire_o (timer_expire)
  );

  // Write-enable is cleared at reset and kept as software last wrote it
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      write_enable_bit <= 1'b0;
    end else if (ctrl_we) begin
      write_enable_bit <= req_enable;
    end
  end

  // Region is frozen during a write so the target stays stable
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      nv_region_select <= nvac_pkg::REGION_DATA_EE;
    end else if (ctrl_we && !write_start_reg) begin
      nv_region_select <= wr_region;
    end
  end

  // Write-start: software sets only, hardware clears at timer expiry
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      write_start_reg <= 1'b0;
    end else if (start_write) begin
      write_start_reg <= 1'b1;
    end else if (timer_expire) begin
      write_start_reg <= 1'b0;
    end
  end

  // Error flag marks a write in flight; reset clears it, as does a control write with the bit at zero that starts no write
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      write_error_flag <= 1'b0;
    end else if (start_write) begin
      write_error_flag <= 1'b1;
    end else if (timer_expire) begin
      write_error_flag <= 1'b0;
    end else if (ctrl_we && !req_err_keep) begin
      write_error_flag <= 1'b0;
    end
  end

  // Read completes in one cycle, so the bit is seen only as a pulse
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      read_start_reg <= 1'b0;
    end else begin
      read_start_reg <= start_read;
    end
  end

  // Latch write target so later register writes cannot disturb it
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_data_reg <= nvac_pkg::RESET_BYTE;
    end else if (start_write) begin
      wr_data_reg <= nv_data_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_addr_reg <= 16'h0000;
    end else if (start_write) begin
      wr_addr_reg <= full_addr;
    end
  end

  // Only the data EEPROM region stores; ID area writes run the timer but drop the byte
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_region_ee_reg <= 1'b0;
    end else if (start_write) begin
      wr_region_ee_reg <= wr_region_ee;
    end
  end

  // Erase-before-write: the byte is replaced whole when the timer expires
  always_ff @(posedge clk_i) begin
    if (timer_expire && wr_region_ee_reg && in_range(wr_addr_reg)) begin
      ee_mem[wr_addr_reg[ADDR_W-1:0]] <= wr_data_reg;
    end
  end

  // Data and address registers
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      nv_data_reg <= nvac_pkg::RESET_BYTE;
    end else if (start_read) begin
      // ID area and out-of-range locations read as zero
      if (wr_region_ee && in_range(full_addr)) begin
        nv_data_reg <= ee_mem[full_addr[ADDR_W-1:0]];
      end else begin
        nv_data_reg <= nvac_pkg::RESET_BYTE;
      end
    end else if (data_we) begin
      nv_data_reg <= pwdata_i[7:0];
    end
  end

  // Address bytes are kept apart so software may write them in either order
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      nv_addr_low_reg <= nvac_pkg::RESET_BYTE;
    end else if (addr_low_we) begin
      nv_addr_low_reg <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      nv_addr_high_reg <= nvac_pkg::RESET_BYTE;
    end else if (addr_high_we) begin
      nv_addr_high_reg <= pwdata_i[7:0];
    end
  end

  // Done flag: set wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      nv_done_irq_flag <= 1'b0;
    end else if (timer_expire) begin
      nv_done_irq_flag <= 1'b1;
    end else if (irq_we && !pwdata_i[nvac_pkg::BIT_DONE_FLAG]) begin
      nv_done_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      nv_done_irq_o <= 1'b0;
    end else begin
      nv_done_irq_o <= nv_done_irq_flag;
    end
  end

  // Read-start shows as a single cycle of one, since a read never waits
  always_comb begin
    nv_control_reg = 8'h00;
    nv_control_reg[nvac_pkg::BIT_READ_START]  = read_start_reg;
    nv_control_reg[nvac_pkg::BIT_WRITE_START] = write_start_reg;
    nv_control_reg[nvac_pkg::BIT_WRITE_EN]    = write_enable_bit;
    nv_control_reg[nvac_pkg::BIT_WRITE_ERR]   = write_error_flag;
    nv_control_reg[nvac_pkg::POS_REGION +: 2] = nv_region_select;
  end

  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (paddr_i)
      nvac_pkg::OFS_CONTROL:   rd_value[7:0] = nv_control_reg;
      // Key register is write-only, so the unlock pattern cannot be read back
      nvac_pkg::OFS_UNLOCK:    rd_value[7:0] = 8'h00;
      nvac_pkg::OFS_DATA:      rd_value[7:0] = nv_data_reg;
      nvac_pkg::OFS_ADDR_LOW:  rd_value[7:0] = nv_addr_low_reg;
      nvac_pkg::OFS_ADDR_HIGH: rd_value[7:0] = nv_addr_high_reg;
      nvac_pkg::OFS_IRQ_FLAGS: rd_value[0]   = nv_done_irq_flag;
      default:                 rd_value = 32'h0000_0000;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= access;
    end
  end

  // The error answer rides on the same cycle as pready
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= access && addr_bad;
    end
  end

  // Read data is captured once and held until the next read
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_acc) begin
      prdata_o <= rd_value;
    end
  end
endmodule

// ### hdl/nvac_pkg.sv
// Purpose: Shared constants for the data EEPROM access controller
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   Offsets are byte addresses
package nvac_pkg;
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_UNLOCK    = 8'h04;
  localparam logic [7:0] OFS_DATA      = 8'h08;
  localparam logic [7:0] OFS_ADDR_LOW  = 8'h0C;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h10;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h14;

  // Control register field positions
  localparam int BIT_READ_START  = 0;
  localparam int BIT_WRITE_START = 1;
  localparam int BIT_WRITE_EN    = 2;
  localparam int BIT_WRITE_ERR   = 3;
  localparam int POS_REGION      = 6;
  // Done flag position in the irq flag register
  localparam int BIT_DONE_FLAG   = 0;

  localparam logic [7:0] UNLOCK_KEY_1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_2 = 8'hAA;

  localparam logic [1:0] REGION_DATA_EE = 2'h0;
  localparam logic [1:0] REGION_PROGRAM = 2'h2;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Erase/write programming time
  localparam int CLK_MHZ        = 250;
  localparam int PROG_TIME_US   = 4;
  localparam int PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
  localparam int PROG_CNT_W     = 16;

  typedef enum logic [1:0] {
    UNL_IDLE,
    UNL_GOT_55,
    UNL_ARMED
  } nvac_unlock_type;
endpackage

// ### hdl/nvac_unlock.sv
// Purpose: Two-step unlock key detector
// Assumes: key_we_i pulses once per write to the unlock register
// Notes:   Any other register write disarms the sequence
module nvac_unlock (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       key_we_i,
  input  wire logic [7:0] key_i,
  input  wire logic       other_we_i,
  input  wire logic       consume_i,
  output logic            armed_o
);
  nvac_pkg::nvac_unlock_type state_reg;
  nvac_pkg::nvac_unlock_type state_next;

  always_comb begin
    state_next = state_reg;
    if (consume_i || other_we_i) begin
      state_next = nvac_pkg::UNL_IDLE;
    end else if (key_we_i) begin
      if (key_i == nvac_pkg::UNLOCK_KEY_1) begin
        state_next = nvac_pkg::UNL_GOT_55;
      end else if (key_i == nvac_pkg::UNLOCK_KEY_2 && state_reg == nvac_pkg::UNL_GOT_55) begin
        state_next = nvac_pkg::UNL_ARMED;
      end else begin
        state_next = nvac_pkg::UNL_IDLE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_reg <= nvac_pkg::UNL_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign armed_o = (state_reg == nvac_pkg::UNL_ARMED);
endmodule

// ### hdl/nvac_prog_timer.sv
// Purpose: Internal programming timer for erase/write
// Assumes: start_i is a one-cycle pulse
// Notes:   expire_o pulses once when the count runs out
module nvac_prog_timer #(
  parameter int CYCLES = nvac_pkg::PROG_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      expire_o
);
  localparam int W = nvac_pkg::PROG_CNT_W;
  logic [W-1:0] cnt_reg;

  if (CYCLES < 1 || CYCLES >= (1 << W)) begin : g_bad_cycles
    $error("Programming time does not fit the counter");
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_reg  <= '0;
      expire_o <= 1'b0;
    end else begin
      expire_o <= (cnt_reg == W'(1));
      if (start_i) begin
        cnt_reg <= W'(CYCLES);
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - W'(1);
      end
    end
  end

  assign busy_o = (cnt_reg != '0);
endmodule

// ### test/nvac_top_props.sv
// Purpose: Port-level checks for the EEPROM access controller
// Assumes: APB master holds each request until pready
// Notes:   Bound into every nvac_top instance
module nvac_top_props #(
  parameter int ADDR_W      = 10,
  parameter int PROG_CYCLES = 1000
) (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        nv_done_irq_o
);
  logic rd_take;
  logic irq_clr_take;
  logic quiet;
  assign rd_take      = psel_i && penable_i && !pready_o && !pwrite_i;
  assign irq_clr_take = psel_i && penable_i && !pready_o && pwrite_i
                        && paddr_i == 8'h14 && !pwdata_i[0];
  assign quiet        = !pready_o && !pslverr_o && !nv_done_irq_o && prdata_o == 32'h0;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence take_s;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence bad_addr_s;
    take_s ##0 (paddr_i > 8'h14 || paddr_i[1:0] != 2'h0);
  endsequence
  one_wait_a: assert property (take_s |=> pready_o)
    else $error("no answer after one wait state");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("pready without an access phase");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("pslverr outside the answer cycle");
  unmapped_err_a: assert property (bad_addr_s |=> pslverr_o)
    else $error("bad address not flagged");
  mapped_ok_a: assert property (take_s ##0 (paddr_i <= 8'h14 && paddr_i[1:0] == 2'h0)
    |=> !pslverr_o) else $error("mapped address flagged");
  rdata_hold_a: assert property ($changed(prdata_o) |-> $past(rd_take))
    else $error("read data moved without a read");
  irq_clear_a: assert property ($fell(nv_done_irq_o) |-> $past(irq_clr_take, 2))
    else $error("done flag cleared without software");
  reset_quiet_a: assert property (disable iff (1'b0) !rstn_i |=> quiet)
    else $error("outputs not quiet after reset");
endmodule

bind nvac_top nvac_top_props #(.ADDR_W(ADDR_W), .PROG_CYCLES(PROG_CYCLES)) u_props (
  .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .nv_done_irq_o(nv_done_irq_o));

// ### test/nvac_ee_model.sv
// Purpose: Behavioural image of the data EEPROM array
// Assumes: Bench stores a byte once its erase/write has completed
// Notes:   Unwritten cells stay unknown, as the real array is never reset
module nvac_ee_model #(
  parameter int AW = 10
);
  logic [7:0] mem [1 << AW];
  // Whole byte replaced: erase and program act as one step
  task automatic store(input logic [AW-1:0] a, input logic [7:0] v);
    mem[a] = v;
  endtask
  function automatic logic [7:0] load(input logic [AW-1:0] a);
    return mem[a];
  endfunction
endmodule

// ### test/tb_data_eeprom_access_control.sv
// Purpose: Register-level test of the data EEPROM access controller
// Assumes: One wait state per APB transfer is not relied upon
// Notes:   Programming time shortened to keep the run brief
module tb_data_eeprom_access_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 40;
  localparam logic [7:0] CTL = nvac_pkg::OFS_CONTROL;
  localparam logic [7:0] KEY = nvac_pkg::OFS_UNLOCK;
  localparam logic [7:0] DAT = nvac_pkg::OFS_DATA;
  localparam logic [7:0] IRQ = nvac_pkg::OFS_IRQ_FLAGS;
  logic        clk_i     = 1'b0;
  logic        rstn_i    = 1'b0;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [7:0]  paddr_i   = 8'h00;
  logic [31:0] pwdata_i  = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        nv_done_irq_o;
  logic [31:0] q;
  logic        err;
  logic [9:0]  al [3] = '{10'h3FF, 10'h100, 10'h001};
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  nvac_top #(.ADDR_W(10), .PROG_CYCLES(P)) u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .nv_done_irq_o(nv_done_irq_o));
  nvac_ee_model #(.AW(10)) u_ee ();

  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  task automatic summarize();
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask

  // Idle cycle first, so no signal is assigned twice in one time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      n_fail++;
      summarize();
    end
    q = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(q, exp);
  endtask

  task automatic arm(input logic [7:0] c, k1, k2, input logic mid);
    wr(CTL, {24'h0, c});
    wr(KEY, {24'h0, k1});
    if (mid) wr(DAT, 32'h0);
    wr(KEY, {24'h0, k2});
    wr(CTL, {24'h0, c | 8'h02});
  endtask

  task automatic set_addr(input logic [9:0] a);
    wr(nvac_pkg::OFS_ADDR_HIGH, {30'h0, a[9:8]});
    wr(nvac_pkg::OFS_ADDR_LOW, {24'h0, a[7:0]});
  endtask

  task automatic ee_write(input logic [9:0] a, input logic [7:0] v);
    int t0;
    int k;
    set_addr(a);
    wr(DAT, {24'h0, v});
    arm(8'h04, 8'h55, 8'hAA, 1'b0);
    t0 = cyc;
    rd(CTL, 32'h0E);
    wr(CTL, 32'h0C);
    rd(CTL, 32'h0E);
    k = 0;
    do begin
      apb(1'b0, CTL, 32'h0);
      k++;
    end while (q[1] !== 1'b0 && k < 100);
    if (k >= 100) begin
      n_fail++;
      summarize();
    end
    cmp(q, 32'h04);
    cmp(32'((cyc - t0) >= P && (cyc - t0) <= P + 20), 32'h1);
    rd(IRQ, 32'h1);
    cmp({31'h0, nv_done_irq_o}, 32'h1);
    wr(IRQ, 32'h0);
    rd(IRQ, 32'h0);
    cmp({31'h0, nv_done_irq_o}, 32'h0);
    u_ee.store(a, v);
  endtask

  task automatic ee_read(input logic [9:0] a);
    set_addr(a);
    wr(CTL, 32'h01);
    rd(DAT, {24'h0, u_ee.load(a)});
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(CTL, 32'h0);
    rd(IRQ, 32'h0);
    ee_write(10'h3FF, 8'hA5);
    ee_read(10'h3FF);
    ee_write(10'h3FF, 8'h5A);
    ee_write(10'h100, 8'h3C);
    ee_write(10'h001, 8'hC3);
    for (int i = 0; i < 3; i++) ee_read(al[i]);
    arm(8'h04, 8'h55, 8'hAA, 1'b1);
    rd(CTL, 32'h04);
    arm(8'h04, 8'hAA, 8'h55, 1'b0);
    rd(CTL, 32'h04);
    arm(8'h00, 8'h55, 8'hAA, 1'b0);
    rd(CTL, 32'h00);
    wr(DAT, 32'h77);
    wr(CTL, 32'h81);
    rd(CTL, 32'h80);
    rd(DAT, 32'h77);
    wr(CTL, 32'h41);
    rd(DAT, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    cmp({31'h0, err}, 32'h1);
    apb(1'b0, 8'h02, 32'h0);
    cmp({31'h0, err}, 32'h1);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(CTL, 32'h0);
    ee_read(10'h100);
    summarize();
  end
endmodule
